// ---- design/ebc_pkg.sv ----
package ebc_pkg;

  // ***************************************************
  // Sizes and strap positions
  // ***************************************************
  localparam int NUM_CHAN = 8;
  localparam int CE_CHANS = 6;
  localparam int STRAP_LO = 3;
  localparam int STRAP_HI = 13;
  localparam int SP_SYS_LO = 3;
  localparam int SP_EXTERNAL_ACK_ENABLE = 5;
  localparam int SP_SPD_LO = 6;
  localparam int SP_EN = 8;
  localparam int SP_BC = 11;
  localparam int SP_BSZ_LO = 12;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // ***************************************************
  // Field codes
  // ***************************************************
  localparam logic [1:0] BSZ_32 = 2'h1;
  localparam logic [1:0] BSZ_16 = 2'h2;
  localparam logic [1:0] BSZ_8 = 2'h3;
  localparam logic [3:0] CS_MAX = 4'hA;
  localparam logic [4:0] UPPER_MIN_CS = 5'h03;
  localparam logic [1:0] SPEED_TOP = 2'h3;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] PAGE_BASE_BITS = 2'h2;

  // ***************************************************
  // Types
  // ***************************************************
  typedef struct packed {
    logic channel_enable;
    logic [1:0] channel_speed;
    logic byte_lane_control;
    logic external_ack_enable;
    logic [1:0] bus_width_code;
    logic page_mode;
    logic [1:0] page_size;
    logic [3:0] chan_size;
    logic [11:0] base;
  } ebc_chan_cfg_t;

  localparam ebc_chan_cfg_t CHAN_RST = '0;

  typedef enum logic [1:0] {
    BK_INC = 2'b00,
    BK_DEC = 2'b01,
    BK_FIX = 2'b10,
    BK_WRAP = 2'b11
  } ebc_burst_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [4:0] beats;
    ebc_burst_t kind;
  } ebc_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_UPPER = 3'b010,
    ST_HOLD = 3'b011,
    ST_LOWER = 3'b100
  } ebc_state_t;

endpackage : ebc_pkg

// ---- design/ebc_chan_decode.sv ----
`timescale 1ns/1ps
module ebc_chan_decode (
  input wire ebc_pkg::ebc_chan_cfg_t cfg,
  input wire logic [11:0] paddr_hi,
  output logic hit,
  output logic uses_upper
);
  import ebc_pkg::*;

  logic [11:0] mask;
  logic [4:0] shift_sum;

  always_comb begin
    mask = 12'((13'h001 << cfg.chan_size) - 13'h001);
    hit = cfg.channel_enable && (cfg.chan_size <= CS_MAX)
      && ((paddr_hi & ~mask) == (cfg.base & ~mask));
    // Narrower buses shift the upper field down, so smaller sizes use it
    case (cfg.bus_width_code)
      BSZ_16: shift_sum = {1'b0, cfg.chan_size} + 5'h01;
      BSZ_8: shift_sum = {1'b0, cfg.chan_size} + 5'h02;
      default: shift_sum = {1'b0, cfg.chan_size};
    endcase
    uses_upper = (shift_sum >= UPPER_MIN_CS);
  end

endmodule : ebc_chan_decode

// ---- design/ebc_addr_out.sv ----
`timescale 1ns/1ps
module ebc_addr_out (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [ebc_pkg::STRAP_HI:ebc_pkg::STRAP_LO] STRAP_ADDR,
  input wire logic ACK_PIN_STATIC_SEL,
  input wire logic UPPER_ADDR_HOLD_SEL,
  input wire logic CFG_WR,
  input wire logic [2:0] CFG_SEL,
  input wire ebc_pkg::ebc_chan_cfg_t CFG_DATA,
  output ebc_pkg::ebc_chan_cfg_t CFG_RD_DATA,
  input wire logic REQ_VALID,
  input wire ebc_pkg::ebc_req_t REQ,
  output logic REQ_READY,
  output logic REQ_MISS,
  output logic BEAT_DONE,
  output logic BUSY,
  output logic [19:0] ADDR_OUT,
  output logic UPPER_ADDR_STROBE,
  output logic [ebc_pkg::CE_CHANS-1:0] CE_N,
  output logic [1:0] CARD_SEL,
  output logic BYTE_LANE_MODE,
  output logic PAGE_HIT,
  output logic ACK_PIN_O,
  output logic ACK_PIN_OE,
  output logic EXTERNAL_SYSTEM_CLOCK_EN,
  output logic [1:0] EXTERNAL_SYSTEM_CLOCK_DIVIDER_SELECT
);
  import ebc_pkg::*;

  // ***************************************************
  // Declarations
  // ***************************************************
  ebc_chan_cfg_t cfg_reg [NUM_CHAN];
  logic [STRAP_HI:STRAP_LO] strap_s1_reg, strap_s2_reg;
  logic [1:0] boot_cnt_reg;
  logic boot_done_reg;
  logic [1:0] sysdiv_reg, sys_cnt_reg;
  ebc_state_t state_reg, state_next;
  ebc_req_t cur_reg;
  logic [2:0] chan_reg;
  logic last_valid_reg;
  logic [7:0] last_upper_reg;
  logic [1:0] phase_cnt_reg;
  logic [19:0] addr_out_reg, prev_lower_reg;
  logic uae_reg, stb_reg, miss_reg, page_hit_reg, first_beat_reg;
  logic ack_n_reg;
  logic [NUM_CHAN-1:0] ce_n_reg;
  logic [NUM_CHAN-1:0] hit_vec, use_up_vec;
  logic hit_any;
  logic [2:0] hit_idx;
  ebc_chan_cfg_t cfg_a;
  logic [31:0] word_addr, next_addr;
  logic [7:0] upper_now;
  logic [19:0] lower_now;
  logic tick, need_up, same_page;
  logic [2:0] page_bits;

  // ***************************************************
  // Channel window decode
  // ***************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      ebc_chan_decode u_dec (
        .cfg(cfg_reg[g]),
        .paddr_hi(REQ.addr[31:20]),
        .hit(hit_vec[g]),
        .uses_upper(use_up_vec[g])
      );
    end
  endgenerate

  // Overlap is undefined, so lowest channel simply wins
  always_comb begin
    hit_idx = 3'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_idx = 3'(i);
      end
    end
    hit_any = |hit_vec;
  end

  // ***************************************************
  // Straps and boot configuration
  // ***************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
    end else begin
      strap_s1_reg <= STRAP_ADDR;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Wait for the synchroniser to fill before loading
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      boot_cnt_reg <= 2'h0;
      boot_done_reg <= 1'b0;
    end else if (!boot_done_reg) begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
      boot_done_reg <= (boot_cnt_reg == STRAP_WAIT);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        cfg_reg[i] <= CHAN_RST;
      end
    end else if (!boot_done_reg) begin
      if (boot_cnt_reg == STRAP_WAIT) begin
        cfg_reg[0].channel_enable <= strap_s2_reg[SP_EN];
        cfg_reg[0].channel_speed <=
          strap_s2_reg[SP_SPD_LO+1:SP_SPD_LO];
        cfg_reg[0].byte_lane_control <= strap_s2_reg[SP_BC];
        cfg_reg[0].external_ack_enable <= ~strap_s2_reg[SP_EXTERNAL_ACK_ENABLE];
        cfg_reg[0].bus_width_code <=
          strap_s2_reg[SP_BSZ_LO+1:SP_BSZ_LO];
      end
    end else if (CFG_WR) begin
      cfg_reg[CFG_SEL] <= CFG_DATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_RD_DATA <= CHAN_RST;
    end else begin
      CFG_RD_DATA <= cfg_reg[CFG_SEL];
    end
  end

  // ***************************************************
  // System clock enable divider
  // ***************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sysdiv_reg <= 2'h0;
      sys_cnt_reg <= 2'h0;
      EXTERNAL_SYSTEM_CLOCK_EN <= 1'b0;
    end else if (!boot_done_reg) begin
      sysdiv_reg <= strap_s2_reg[SP_SYS_LO+1:SP_SYS_LO];
      sys_cnt_reg <= 2'h0;
      EXTERNAL_SYSTEM_CLOCK_EN <= 1'b0;
    end else begin
      // Code c divides by 4 - c: terminal count is 3 - c
      EXTERNAL_SYSTEM_CLOCK_EN <= (sys_cnt_reg == SPEED_TOP - sysdiv_reg);
      if (sys_cnt_reg == SPEED_TOP - sysdiv_reg) begin
        sys_cnt_reg <= 2'h0;
      end else begin
        sys_cnt_reg <= sys_cnt_reg + 2'h1;
      end
    end
  end
  assign EXTERNAL_SYSTEM_CLOCK_DIVIDER_SELECT = sysdiv_reg;

  // ***************************************************
  // Address formation for the active channel
  // ***************************************************
  always_comb begin
    cfg_a = cfg_reg[chan_reg];
    case (cfg_a.bus_width_code)
      BSZ_16: word_addr = {1'b0, cur_reg.addr[31:1]};
      BSZ_8: word_addr = cur_reg.addr;
      default: word_addr = {2'b00, cur_reg.addr[31:2]};
    endcase
    upper_now = word_addr[27:20];
    lower_now = word_addr[19:0];
    need_up = !last_valid_reg
      || (use_up_vec[chan_reg] && upper_now != last_upper_reg);
    tick = (phase_cnt_reg == SPEED_TOP - cfg_a.channel_speed);
    case (cfg_a.page_size)
      // Three bits: sixteen-word pages shift by four
      2'h1: page_bits = {1'b0, PAGE_BASE_BITS} + 3'h1;
      2'h2: page_bits = {1'b0, PAGE_BASE_BITS} + 3'h2;
      default: page_bits = {1'b0, PAGE_BASE_BITS};
    endcase
    same_page = (((lower_now ^ prev_lower_reg) >> page_bits) == 20'h0);
    case (cur_reg.kind)
      BK_DEC: next_addr = cur_reg.addr - WORD_STEP;
      BK_FIX: next_addr = cur_reg.addr;
      // Critical word first: wrap inside the eight-word line
      BK_WRAP: next_addr = {cur_reg.addr[31:5],
        cur_reg.addr[4:2] + 3'h1, cur_reg.addr[1:0]};
      default: next_addr = cur_reg.addr + WORD_STEP;
    endcase
  end

  // ***************************************************
  // Cycle sequencer
  // ***************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (REQ_VALID && boot_done_reg && hit_any) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        state_next = need_up ? ST_UPPER : ST_LOWER;
      end
      ST_UPPER: begin
        if (tick) begin
          state_next = UPPER_ADDR_HOLD_SEL ? ST_HOLD : ST_LOWER;
        end
      end
      ST_HOLD: begin
        state_next = ST_LOWER;
      end
      ST_LOWER: begin
        if (tick) begin
          state_next = (cur_reg.beats <= 5'h01) ? ST_IDLE : ST_START;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_cnt_reg <= 2'h0;
    end else if (state_next != state_reg || tick) begin
      phase_cnt_reg <= 2'h0;
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 2'h1;
    end
  end

  // Request capture and burst stepping
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_reg <= '0;
      chan_reg <= 3'h0;
      first_beat_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && REQ_VALID && boot_done_reg) begin
      cur_reg <= REQ;
      chan_reg <= hit_idx;
      first_beat_reg <= 1'b1;
    end else if (state_reg == ST_LOWER && tick
                 && cur_reg.beats > 5'h01) begin
      cur_reg.addr <= next_addr;
      cur_reg.beats <= cur_reg.beats - 5'h01;
      first_beat_reg <= 1'b0;
    end
  end

  // Last upper pattern: invalid until the first strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      last_valid_reg <= 1'b0;
      last_upper_reg <= 8'h00;
    end else if (state_reg == ST_START && need_up) begin
      last_valid_reg <= 1'b1;
      last_upper_reg <= upper_now;
    end
  end

  // ***************************************************
  // Pin side registers
  // ***************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_out_reg <= 20'h0_0000;
      uae_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_START: begin
          if (need_up) begin
            addr_out_reg[19:12] <= upper_now;
            uae_reg <= 1'b1;
          end else begin
            addr_out_reg <= lower_now;
          end
        end
        ST_UPPER: begin
          if (tick) begin
            uae_reg <= 1'b0;
            if (!UPPER_ADDR_HOLD_SEL) begin
              addr_out_reg <= lower_now;
            end
          end
        end
        ST_HOLD: begin
          addr_out_reg <= lower_now;
        end
        default: begin
          uae_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ce_n_reg <= '1;
      prev_lower_reg <= 20'h0_0000;
      page_hit_reg <= 1'b0;
    end else if (state_next == ST_LOWER && state_reg != ST_LOWER) begin
      ce_n_reg <= ~(NUM_CHAN'(1) << chan_reg);
      prev_lower_reg <= lower_now;
      page_hit_reg <= cfg_a.page_mode && !first_beat_reg
        && same_page;
    end else if (state_next != ST_LOWER) begin
      ce_n_reg <= '1;
      page_hit_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stb_reg <= 1'b0;
      miss_reg <= 1'b0;
      ack_n_reg <= 1'b1;
    end else begin
      stb_reg <= (state_reg == ST_LOWER) && tick;
      miss_reg <= (state_reg == ST_IDLE) && REQ_VALID
        && boot_done_reg && !hit_any;
      // Internal ack only when the channel does not wait for one
      ack_n_reg <= !((state_reg == ST_LOWER) && tick
        && !cfg_a.external_ack_enable);
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign REQ_READY = (state_reg == ST_IDLE) && boot_done_reg;
  assign BUSY = (state_reg != ST_IDLE);
  assign REQ_MISS = miss_reg;
  assign BEAT_DONE = stb_reg;
  assign ADDR_OUT = addr_out_reg;
  assign UPPER_ADDR_STROBE = uae_reg;
  // Channels 6 and 7 have no chip enable pin, only a card select
  assign CE_N = ce_n_reg[CE_CHANS-1:0];
  assign CARD_SEL = ~ce_n_reg[NUM_CHAN-1:CE_CHANS];
  assign BYTE_LANE_MODE = cfg_a.byte_lane_control;
  assign PAGE_HIT = page_hit_reg;
  assign ACK_PIN_O = ack_n_reg;
  // Static mode never drives; dynamic drives unless waiting for input
  assign ACK_PIN_OE = !ACK_PIN_STATIC_SEL
    && !(BUSY && cfg_a.external_ack_enable);

  // ***************************************************
  // Assertions
  // ***************************************************
  first_upper_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state_reg == ST_START && !last_valid_reg |=> uae_reg
      && addr_out_reg[19:12] == last_upper_reg)
    else $error("first access skipped the upper phase");

  small_skip_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state_reg == ST_START && last_valid_reg && !use_up_vec[chan_reg]
      |=> !uae_reg && state_reg == ST_LOWER)
    else $error("upper strobe on a small channel");

  addr_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(uae_reg) && UPPER_ADDR_HOLD_SEL
      |-> $stable(addr_out_reg) ##1 state_reg == ST_LOWER)
    else $error("address not held after the strobe");

  no_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(uae_reg) && !UPPER_ADDR_HOLD_SEL |-> state_reg == ST_LOWER)
    else $error("address late without hold");

  quarter_speed_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $changed(state_reg) && state_reg == ST_LOWER
      && cfg_a.channel_speed == 2'h0
      |-> (state_reg == ST_LOWER) [*4] ##1 state_reg != ST_LOWER)
    else $error("quarter speed phase is not four clocks");

  decr_step_a: assert property (@(posedge CLK) disable iff (!RST_N)
    stb_reg && cur_reg.kind == BK_DEC && $past(cur_reg.beats) > 5'h01
      |-> cur_reg.addr == $past(cur_reg.addr) - WORD_STEP)
    else $error("decrementing burst stepped wrongly");

  boot_load_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(boot_done_reg) |-> cfg_reg[0].channel_enable
      == strap_s2_reg[SP_EN] && cfg_reg[0].external_ack_enable
      == !strap_s2_reg[SP_EXTERNAL_ACK_ENABLE])
    else $error("boot channel not loaded from straps");

  external_system_clock_div_a: assert property (@(posedge CLK) disable iff (!RST_N)
    EXTERNAL_SYSTEM_CLOCK_EN && sysdiv_reg == 2'h0
      |=> !EXTERNAL_SYSTEM_CLOCK_EN [*3] ##1 EXTERNAL_SYSTEM_CLOCK_EN)
    else $error("system clock enable period wrong");

  ack_idle_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !ACK_PIN_STATIC_SEL && state_reg == ST_IDLE && !stb_reg
      |-> ACK_PIN_OE && ACK_PIN_O)
    else $error("dynamic ack pin not driven high when idle");

  card_ce_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state_reg == ST_LOWER && chan_reg >= 3'(CE_CHANS) |-> &CE_N)
    else $error("chip enable driven for a card channel");

endmodule : ebc_addr_out

// ---- dv/ebc_ext_dev.sv ----
`timescale 1ns/1ps
// ********
// Board-side latch and address capture model
// ********
module ebc_ext_dev (
  input wire logic clk,
  input wire logic [19:0] addr,
  input wire logic strobe,
  input wire logic [5:0] ce_n,
  input wire logic [1:0] card_sel,
  output logic [7:0] upper_latch,
  output logic [19:0] hold_addr,
  output logic [19:0] last_low,
  output logic [7:0] last_act,
  output int strobe_cnt
);
  logic prev_strobe;
  logic [7:0] prev_act;
  logic [19:0] prev_addr;
  logic [7:0] act;
  assign act = {card_sel, ~ce_n};
  initial begin
    prev_strobe = 1'b0;
    prev_act = 8'h00;
    prev_addr = 20'h00000;
    strobe_cnt = 0;
    upper_latch = 8'h00;
  end
  // Strobe wired as a transparent latch enable
  always @* begin
    if (strobe) begin
      upper_latch = addr[19:12];
    end
  end
  // A beat shows as a fresh select or a moved address
  always @(posedge clk) begin
    if (strobe && !prev_strobe) begin
      strobe_cnt <= strobe_cnt + 1;
    end
    if (prev_strobe && !strobe) begin
      hold_addr <= addr;
    end
    if (act != 8'h00 && (act != prev_act || addr != prev_addr)) begin
      last_low <= addr;
      last_act <= act;
    end
    prev_strobe <= strobe;
    prev_act <= act;
    prev_addr <= addr;
  end
endmodule : ebc_ext_dev

// ---- dv/test_ext_bus_chan_decode_addr_out.sv ----
`timescale 1ns/1ps
module test_ext_bus_chan_decode_addr_out;
  import ebc_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [STRAP_HI:STRAP_LO] STRAP_ADDR = 11'h33D;
  logic ACK_PIN_STATIC_SEL = 1'b0;
  logic UPPER_ADDR_HOLD_SEL = 1'b1;
  logic CFG_WR = 1'b0;
  logic [2:0] CFG_SEL = 3'h0;
  ebc_chan_cfg_t CFG_DATA = CHAN_RST;
  ebc_chan_cfg_t CFG_RD_DATA;
  logic REQ_VALID = 1'b0;
  ebc_req_t REQ = '0;
  logic REQ_READY, REQ_MISS, BEAT_DONE, BUSY, UPPER_ADDR_STROBE;
  logic BYTE_LANE_MODE, PAGE_HIT, ACK_PIN_O, ACK_PIN_OE, EXTERNAL_SYSTEM_CLOCK_EN;
  logic [19:0] ADDR_OUT;
  logic [CE_CHANS-1:0] CE_N;
  logic [1:0] CARD_SEL, EXTERNAL_SYSTEM_CLOCK_DIVIDER_SELECT;
  logic [7:0] up_latch, low_act;
  logic [19:0] hold_addr, last_low;
  int strobe_cnt;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int lat;
  int pg;
  logic miss;
  logic have_up = 1'b0;
  logic [7:0] last_up = 8'h00;

  ebc_addr_out ebc_addr_out_inst (
    .CLK(CLK), .RST_N(RST_N), .STRAP_ADDR(STRAP_ADDR),
    .ACK_PIN_STATIC_SEL(ACK_PIN_STATIC_SEL),
    .UPPER_ADDR_HOLD_SEL(UPPER_ADDR_HOLD_SEL), .CFG_WR(CFG_WR),
    .CFG_SEL(CFG_SEL), .CFG_DATA(CFG_DATA), .CFG_RD_DATA(CFG_RD_DATA),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
    .REQ_MISS(REQ_MISS), .BEAT_DONE(BEAT_DONE), .BUSY(BUSY),
    .ADDR_OUT(ADDR_OUT), .UPPER_ADDR_STROBE(UPPER_ADDR_STROBE),
    .CE_N(CE_N), .CARD_SEL(CARD_SEL), .BYTE_LANE_MODE(BYTE_LANE_MODE),
    .PAGE_HIT(PAGE_HIT), .ACK_PIN_O(ACK_PIN_O), .ACK_PIN_OE(ACK_PIN_OE),
    .EXTERNAL_SYSTEM_CLOCK_EN(EXTERNAL_SYSTEM_CLOCK_EN), .EXTERNAL_SYSTEM_CLOCK_DIVIDER_SELECT(EXTERNAL_SYSTEM_CLOCK_DIVIDER_SELECT)
  );

  ebc_ext_dev ebc_ext_dev_inst (
    .clk(CLK), .addr(ADDR_OUT), .strobe(UPPER_ADDR_STROBE), .ce_n(CE_N),
    .card_sel(CARD_SEL), .upper_latch(up_latch), .hold_addr(hold_addr),
    .last_low(last_low), .last_act(low_act), .strobe_cnt(strobe_cnt)
  );

  always #2.5 CLK = ~CLK;

  // ********
  // Shared tasks
  // ********
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // Cut a hang short well past the expected run length
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic do_reset(input logic [10:0] s);
    @(posedge CLK);
    RST_N <= 1'b0;
    STRAP_ADDR <= s;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (6) @(posedge CLK);
    have_up = 1'b0;
  endtask : do_reset

  function automatic ebc_chan_cfg_t mk(input logic [1:0] spd,
      input logic [1:0] w, input logic [3:0] cs, input logic [11:0] b);
    ebc_chan_cfg_t c;
    c = CHAN_RST;
    c.channel_enable = 1'b1;
    c.channel_speed = spd;
    c.bus_width_code = w;
    c.chan_size = cs;
    c.base = b;
    return c;
  endfunction : mk

  // Enable goes in last, after the window is in place
  task automatic cfg(input int ch, input ebc_chan_cfg_t c);
    ebc_chan_cfg_t c0;
    c0 = c;
    c0.channel_enable = 1'b0;
    @(posedge CLK);
    CFG_WR <= 1'b1;
    CFG_SEL <= 3'(ch);
    CFG_DATA <= c0;
    @(posedge CLK);
    CFG_DATA <= c;
    @(posedge CLK);
    CFG_WR <= 1'b0;
  endtask : cfg

  task automatic access(input logic [31:0] a, input int beats,
                        input ebc_burst_t k);
    int n;
    n = 0;
    miss = 1'b0;
    lat = 0;
    pg = 0;
    while (REQ_READY !== 1'b1) @(posedge CLK);
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ <= '{addr: a, beats: 5'(beats), kind: k};
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    // Miss pulse stands only in the cycle after acceptance
    while (n < beats && !miss && lat < 200) begin
      #1;
      lat++;
      if (BEAT_DONE === 1'b1) n++;
      if (REQ_MISS === 1'b1) miss = 1'b1;
      if (PAGE_HIT === 1'b1) pg++;
      if (n < beats && !miss) @(posedge CLK);
    end
    if (!miss) chk(32'(n), 32'(beats), "beats");
  endtask : access

  task automatic one(input logic [31:0] a, input int ch, input int sh,
                     input bit up);
    int s0;
    logic [7:0] u;
    logic want;
    s0 = strobe_cnt;
    u = 8'(a >> (22 - sh));
    want = !have_up || (up && u !== last_up);
    access(a, 1, BK_INC);
    chk(32'(strobe_cnt - s0), 32'(want), "strobe");
    chk(32'(last_low), 32'(20'(a >> (2 - sh))), "lower");
    chk(32'(low_act), 32'(8'h01 << ch), "select");
    if (want) begin
      chk(32'(up_latch), 32'(u), "upper");
      last_up = u;
      have_up = 1'b1;
    end
  endtask : one

  // ********
  // Scenarios
  // ********
  task automatic test_boot();
    logic [10:0] s;
    int p;
    for (int i = 0; i < 5; i++) begin
      s = {2'((i % 3) + 1), i[0], 2'h0, i < 4, i[1:0], i[0], i[1:0]};
      do_reset(s);
      CFG_SEL <= 3'h0;
      repeat (2) @(posedge CLK);
      #1;
      chk(32'(CFG_RD_DATA.channel_enable), 32'(i < 4), "en");
      if (i < 4) chk(32'(CFG_RD_DATA.channel_speed), 32'(i), "spd");
      chk(32'(CFG_RD_DATA.byte_lane_control), 32'(i[0]), "bc");
      chk(32'(CFG_RD_DATA.external_ack_enable), 32'(!i[0]), "ack");
      chk(32'(CFG_RD_DATA.bus_width_code), 32'((i % 3) + 1), "w");
      chk(32'(EXTERNAL_SYSTEM_CLOCK_DIVIDER_SELECT), 32'(i % 4), "div");
      p = 0;
      repeat (12) begin
        @(posedge CLK);
        #1;
        if (EXTERNAL_SYSTEM_CLOCK_EN === 1'b1) p++;
      end
      chk(32'(p), 32'(12 / (4 - (i % 4))), "external_system_clock");
    end
    do_reset(11'h33D);
    @(posedge CLK);
    ACK_PIN_STATIC_SEL <= 1'b1;
    @(posedge CLK);
    #1;
    chk(32'(ACK_PIN_OE), 32'h0, "oe static");
    @(posedge CLK);
    ACK_PIN_STATIC_SEL <= 1'b0;
    @(posedge CLK);
    #1;
    chk(32'(ACK_PIN_OE), 32'h1, "oe dynamic");
    chk(32'(ACK_PIN_O), 32'h1, "ack idle");
    $display("boot test done");
  endtask : test_boot

  // Windows kept apart so no address hits two channels
  task automatic test_map();
    cfg(1, mk(2'h3, BSZ_32, 4'h3, 12'h100));
    cfg(2, mk(2'h3, BSZ_16, 4'h2, 12'h200));
    cfg(3, mk(2'h3, BSZ_8, 4'h1, 12'h300));
    cfg(4, mk(2'h3, BSZ_32, 4'h2, 12'h400));
    cfg(6, mk(2'h3, BSZ_32, 4'h0, 12'h600));
    one(32'h0000_1230, 0, 0, 0);
    chk(32'(lat), 32'h5, "first lat");
    chk(32'(hold_addr[19:12]), 32'h0, "held upper");
    one(32'h0000_5678, 0, 0, 0);
    one(32'h1000_0040, 1, 0, 1);
    one(32'h1040_0000, 1, 0, 1);
    one(32'h1070_0100, 1, 0, 1);
    one(32'h2000_0002, 2, 1, 1);
    one(32'h3010_0003, 3, 2, 1);
    one(32'h4030_0010, 4, 0, 0);
    one(32'h6000_0008, 6, 0, 0);
    access(32'h1080_0000, 1, BK_INC);
    chk(32'(miss), 32'h1, "miss");
    chk(32'(lat), 32'h1, "miss lat");
    @(posedge CLK);
    UPPER_ADDR_HOLD_SEL <= 1'b0;
    one(32'h1000_0044, 1, 0, 1);
    chk(32'(hold_addr), 32'h11, "no hold");
    @(posedge CLK);
    UPPER_ADDR_HOLD_SEL <= 1'b1;
    $display("map test done");
  endtask : test_map

  task automatic test_burst();
    logic [19:0] e [4];
    e = '{20'h00008, 20'h00006, 20'h00007, 20'h00000};
    for (int k = 0; k < 4; k++) begin
      access(32'h1000_001C, 2, ebc_burst_t'(k));
      chk(32'(last_low), 32'(e[k]), "burst");
    end
    $display("burst test done");
  endtask : test_burst

  task automatic test_speed();
    int l3;
    l3 = 0;
    for (int s = 3; s >= 0; s--) begin
      cfg(4, mk(2'(s), BSZ_32, 4'h2, 12'h400));
      access(32'h4000_0000, 1, BK_INC);
      if (s == 3) l3 = lat;
      chk(32'(lat - l3), 32'(3 - s), "speed");
    end
    $display("speed test done");
  endtask : test_speed

  task automatic test_page();
    ebc_chan_cfg_t c;
    c = mk(2'h3, BSZ_32, 4'h2, 12'h500);
    c.page_mode = 1'b1;
    c.page_size = 2'h2;
    c.byte_lane_control = 1'b1;
    cfg(5, c);
    access(32'h5000_0000, 2, BK_INC);
    chk(32'(pg), 32'h1, "page hit");
    chk(32'(BYTE_LANE_MODE), 32'h1, "lane mode");
    access(32'h5000_003C, 2, BK_INC);
    chk(32'(pg), 32'h0, "page cross");
    $display("page test done");
  endtask : test_page

  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (6) @(posedge CLK);
    test_boot();
    test_map();
    test_burst();
    test_speed();
    test_page();
    report_and_stop();
  end
endmodule : test_ext_bus_chan_decode_addr_out
